/* File: verilog/tick_counter_pkg.sv */
// Constants shared by the low-power tick counter design.
// Assumes a single core clock; the slow reference clock is sampled as data.
package tick_counter_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W   = 24;
  localparam int unsigned PRESC_W = 12;
  localparam int unsigned ADDR_W  = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_TASK_START = 12'h000;
  localparam logic [11:0] OFF_TASK_STOP  = 12'h004;
  localparam logic [11:0] OFF_TASK_CLEAR = 12'h008;
  localparam logic [11:0] OFF_TASK_FORCE = 12'h00C;
  localparam logic [11:0] OFF_EVT_TICK   = 12'h100;
  localparam logic [11:0] OFF_EVT_WRAP   = 12'h104;
  localparam logic [11:0] OFF_EVT_CMP0   = 12'h140;
  localparam logic [11:0] OFF_ROUTE      = 12'h340;
  localparam logic [11:0] OFF_ROUTE_SET  = 12'h344;
  localparam logic [11:0] OFF_ROUTE_CLR  = 12'h348;
  localparam logic [11:0] OFF_COUNTER    = 12'h504;
  localparam logic [11:0] OFF_PRESC      = 12'h508;
  localparam logic [11:0] OFF_CC0        = 12'h540;

  // ----------------------------------------------------------------
  // Values after reset, fixed loads and the wrap point
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_COUNT  = 24'h000000;
  localparam logic [11:0] RST_PRESC  = 12'h000;
  localparam logic [23:0] RST_CC     = 24'h000000;
  localparam logic [23:0] NEAR_WRAP  = 24'hFFFFF0;
  localparam logic [23:0] COUNT_MAX  = 24'hFFFFFF;

  // ----------------------------------------------------------------
  // Task and event bit positions
  // ----------------------------------------------------------------
  localparam int unsigned TSK_START = 0;
  localparam int unsigned TSK_STOP  = 1;
  localparam int unsigned TSK_CLEAR = 2;
  localparam int unsigned TSK_FORCE = 3;
  localparam int unsigned EV_TICK   = 0;
  localparam int unsigned EV_WRAP   = 1;
  localparam int unsigned EV_CMP0   = 2;

  // ----------------------------------------------------------------
  // Bus timing: index of the last wait cycle before ready
  // ----------------------------------------------------------------
  localparam logic [1:0] WAIT_LAST_PLAIN   = 2'h0;
  localparam logic [1:0] WAIT_LAST_COUNTER = 2'h2;

endpackage

/* File: verilog/level_sync.sv */
// Two-stage synchroniser for one level.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps
module level_sync
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  logic meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

/* File: verilog/compare_channel.sv */
// One compare channel: holds its compare value and flags a match.
// Assumes step and count_next come from the counter core in the same cycle.
`timescale 1ns/1ps
module compare_channel
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [23:0] wdata,
  input  wire logic        step,
  input  wire logic [23:0] count_next,
  output logic      [23:0] cc_q,
  output logic             match_q
);

  // Only a counting step can match, so clear and start never do.
  wire hit = step & (count_next == cc_q);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cc_q    <= tick_counter_pkg::RST_CC;
      match_q <= 1'b0;
    end
    else
    begin
      if (wr_en)
        cc_q <= wdata;
      match_q <= hit;
    end
  end

  property p_step_match;
    @(posedge core_clk) disable iff (!rst_n)
    (step && count_next == cc_q) |=> match_q;
  endproperty
  a_step_match: assert property (p_step_match) else $error("compare step missed");

  property p_no_step_no_match;
    @(posedge core_clk) disable iff (!rst_n)
    !step |=> !match_q;
  endproperty
  a_no_step_no_match: assert property (p_no_step_no_match) else $error("match without step");

endmodule

/* File: verilog/low_power_tick_counter.sv */
// Low-power tick counter with APB register access.
// Assumes the slow reference clock arrives as a plain input on core_clk.
`timescale 1ns/1ps
module low_power_tick_counter
#(
  parameter int unsigned CH = 4
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        low_freq_clock,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [CH+1:0]    event_pulse,
  output logic             clk_request
);

  localparam int unsigned NEV = CH + 2;

  // ----------------------------------------------------------------
  // Slow clock edge detection
  // ----------------------------------------------------------------
  logic lf_sync;
  logic lf_prev_q;

  level_sync level_sync_inst
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (low_freq_clock),
    .dout     (lf_sync)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      lf_prev_q <= 1'b0;
    else
      lf_prev_q <= lf_sync;
  end

  wire lf_rise = lf_sync & ~lf_prev_q;
  wire lf_fall = ~lf_sync & lf_prev_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [1:0]     wait_q;
  logic           pready_q;
  logic [NEV-1:0] route_q;
  logic [NEV-1:0] flag_q;
  logic [23:0]    count_q;
  logic [11:0]    presc_cfg_q;
  logic [11:0]    pcnt_q;
  logic           run_q;
  logic [3:0]     pend_q;
  logic [3:0]     arm_q;
  logic [CH-1:0]  cc_hit;
  logic [NEV-1:0] evt_hit;
  logic [CH-1:0]  cmp_match;
  logic [23:0]    cc_val [CH];
  logic [31:0]    rd_word;
  logic [23:0]    count_d;
  logic [11:0]    pcnt_d;
  logic           run_d;
  logic           step;

  wire acc       = psel & penable;
  wire done      = acc & pready_q;
  wire wr_en     = done & pwrite;
  wire hit_ctr   = (paddr == tick_counter_pkg::OFF_COUNTER);
  wire hit_presc = (paddr == tick_counter_pkg::OFF_PRESC);
  wire hit_route = (paddr == tick_counter_pkg::OFF_ROUTE);
  wire hit_rset  = (paddr == tick_counter_pkg::OFF_ROUTE_SET);
  wire hit_rclr  = (paddr == tick_counter_pkg::OFF_ROUTE_CLR);
  wire [3:0] hit_task = {paddr == tick_counter_pkg::OFF_TASK_FORCE,
                         paddr == tick_counter_pkg::OFF_TASK_CLEAR,
                         paddr == tick_counter_pkg::OFF_TASK_STOP,
                         paddr == tick_counter_pkg::OFF_TASK_START};
  assign evt_hit[tick_counter_pkg::EV_TICK] = (paddr == tick_counter_pkg::OFF_EVT_TICK);
  assign evt_hit[tick_counter_pkg::EV_WRAP] = (paddr == tick_counter_pkg::OFF_EVT_WRAP);

  wire mapped = hit_ctr | hit_presc | hit_route | hit_rset | hit_rclr
              | (|hit_task) | (|evt_hit) | (|cc_hit);
  wire [1:0] wait_last = (hit_ctr & ~pwrite) ? tick_counter_pkg::WAIT_LAST_COUNTER
                                             : tick_counter_pkg::WAIT_LAST_PLAIN;
  // Counter reads hold ready low for two extra cycles to sample safely.
  wire pready_d = acc & ~pready_q & (wait_q == wait_last);
  wire [1:0] wait_d = (acc & ~pready_q) ? wait_q + 2'h1 : 2'h0;
  wire [3:0] task_wr = {4{wr_en & pwdata[0]}} & hit_task;
  wire [NEV-1:0] route_w = pwdata[NEV-1:0];
  wire [NEV-1:0] route_d = (wr_en & hit_route) ? route_w
                         : (wr_en & hit_rset)  ? (route_q | route_w)
                         : (wr_en & hit_rclr)  ? (route_q & ~route_w)
                         : route_q;

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < CH; c++)
    begin : g_ch
      assign cc_hit[c] = (paddr == tick_counter_pkg::OFF_CC0 + 12'(4 * c));
      assign evt_hit[tick_counter_pkg::EV_CMP0 + c] =
        (paddr == tick_counter_pkg::OFF_EVT_CMP0 + 12'(4 * c));
      compare_channel compare_channel_inst
      (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .wr_en      (wr_en & cc_hit[c]),
        .wdata      (pwdata[23:0]),
        .step       (step),
        .count_next (count_d),
        .cc_q       (cc_val[c]),
        .match_q    (cmp_match[c])
      );
    end
  endgenerate

  always_comb
  begin
    rd_word = 32'h00000000;
    if (hit_ctr)
      rd_word = {8'h00, count_q};
    else if (hit_presc)
      rd_word = {20'h00000, presc_cfg_q};
    else if (hit_route | hit_rset | hit_rclr)
      rd_word = 32'(route_q);
    for (int i = 0; i < NEV; i++)
      if (evt_hit[i])
        rd_word = {31'h00000000, flag_q[i]};
    for (int i = 0; i < CH; i++)
      if (cc_hit[i])
        rd_word = {8'h00, cc_val[i]};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wait_q   <= 2'h0;
      pready_q <= 1'b0;
      prdata   <= 32'h00000000;
      pslverr  <= 1'b0;
    end
    else
    begin
      wait_q   <= wait_d;
      pready_q <= pready_d;
      prdata   <= pready_d ? rd_word : 32'h00000000;
      pslverr  <= pready_d & ~mapped;
    end
  end

  assign pready = pready_q;

  // ----------------------------------------------------------------
  // Task crossing: pend until a falling edge, act on the next rise
  // ----------------------------------------------------------------
  wire [3:0] pend_d = task_wr | (pend_q & ~{4{lf_fall}});
  wire [3:0] arm_d  = (lf_fall ? (arm_q | pend_q) : arm_q) & ~{4{lf_rise}};
  wire [3:0] apply  = arm_q & {4{lf_rise}};

  // ----------------------------------------------------------------
  // Counter core, advanced only on slow clock rising edges
  // ----------------------------------------------------------------
  always_comb
  begin
    count_d = count_q;
    pcnt_d  = pcnt_q;
    run_d   = run_q;
    step    = 1'b0;
    if (apply[tick_counter_pkg::TSK_STOP])
      run_d = 1'b0;
    if (apply[tick_counter_pkg::TSK_START])
      run_d = 1'b1;
    if (apply[tick_counter_pkg::TSK_CLEAR])
    begin
      count_d = tick_counter_pkg::RST_COUNT;
      pcnt_d  = presc_cfg_q;
    end
    else if (apply[tick_counter_pkg::TSK_FORCE])
    begin
      count_d = tick_counter_pkg::NEAR_WRAP;
      pcnt_d  = presc_cfg_q;
    end
    else if (apply[tick_counter_pkg::TSK_START])
      pcnt_d = presc_cfg_q;
    else if (lf_rise & run_q)
    begin
      if (pcnt_q == 12'h000)
      begin
        count_d = count_q + 24'h000001;
        pcnt_d  = presc_cfg_q;
        step    = 1'b1;
      end
      else
        pcnt_d = pcnt_q - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Events, routing and clock request
  // ----------------------------------------------------------------
  logic [1:0] ev_q;
  wire [NEV-1:0] ev_raw = {cmp_match, ev_q};
  // A masked event neither sets its flag nor asks for the fast clocks.
  wire [NEV-1:0] routed = ev_raw & route_q;
  logic [NEV-1:0] flag_wr;

  generate
    for (c = 0; c < NEV; c++)
    begin : g_flag
      assign flag_wr[c] = wr_en & evt_hit[c];
    end
  endgenerate

  // Hardware set wins over a software clear in the same cycle.
  wire [NEV-1:0] flag_d = routed | (flag_wr & {NEV{pwdata[0]}})
                        | (flag_q & ~flag_wr);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count_q     <= tick_counter_pkg::RST_COUNT;
      pcnt_q      <= tick_counter_pkg::RST_PRESC;
      presc_cfg_q <= tick_counter_pkg::RST_PRESC;
      run_q       <= 1'b0;
      pend_q      <= 4'h0;
      arm_q       <= 4'h0;
      route_q     <= '0;
      flag_q      <= '0;
      ev_q        <= 2'h0;
      event_pulse <= '0;
      clk_request <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      pcnt_q  <= pcnt_d;
      run_q   <= run_d;
      pend_q  <= pend_d;
      arm_q   <= arm_d;
      route_q <= route_d;
      flag_q  <= flag_d;
      if (wr_en & hit_presc & ~run_q)
        presc_cfg_q <= pwdata[11:0];
      ev_q <= {step & (count_q == tick_counter_pkg::COUNT_MAX), step};
      event_pulse <= routed;
      clk_request <= |routed;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_presc_locked;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_en && hit_presc && run_q) |=> $stable(presc_cfg_q);
  endproperty
  a_presc_locked: assert property (p_presc_locked) else $error("prescaler changed while running");

  property p_step_reload;
    @(posedge core_clk) disable iff (!rst_n)
    (lf_rise && run_q && apply == 4'h0 && pcnt_q == 12'h000)
      |=> (count_q == $past(count_q) + 24'h000001) && (pcnt_q == $past(presc_cfg_q));
  endproperty
  a_step_reload: assert property (p_step_reload) else $error("increment or reload wrong");

  property p_down_count;
    @(posedge core_clk) disable iff (!rst_n)
    (lf_rise && run_q && apply == 4'h0 && pcnt_q != 12'h000)
      |=> (pcnt_q == $past(pcnt_q) - 12'h001) && $stable(count_q);
  endproperty
  a_down_count: assert property (p_down_count) else $error("down-count step wrong");

  property p_force_load;
    @(posedge core_clk) disable iff (!rst_n)
    (apply[tick_counter_pkg::TSK_FORCE] && !apply[tick_counter_pkg::TSK_CLEAR])
      |=> count_q == tick_counter_pkg::NEAR_WRAP;
  endproperty
  a_force_load: assert property (p_force_load) else $error("force did not load near-wrap");

  property p_only_slow_edges;
    @(posedge core_clk) disable iff (!rst_n)
    !lf_rise |=> $stable(count_q) && $stable(run_q);
  endproperty
  a_only_slow_edges: assert property (p_only_slow_edges) else $error("count moved off edge");

  property p_wrap_event;
    @(posedge core_clk) disable iff (!rst_n)
    (step && count_q == tick_counter_pkg::COUNT_MAX && route_q[1])
      |=> ##1 (event_pulse[1] && count_q == 24'h000000);
  endproperty
  a_wrap_event: assert property (p_wrap_event) else $error("wrap event missing");

  property p_masked_flag;
    @(posedge core_clk) disable iff (!rst_n)
    (!route_q[0] && !flag_wr[0]) |=> (flag_q[0] == $past(flag_q[0]));
  endproperty
  a_masked_flag: assert property (p_masked_flag) else $error("masked event set flag");

  property p_counter_read;
    @(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && hit_ctr && !pready_q)
      ##1 (psel && penable && hit_ctr && !pwrite) |-> !pready_q [*3] ##1 pready_q;
  endproperty
  a_counter_read: assert property (p_counter_read) else $error("counter read not five cycles");

  property p_task_waits;
    @(posedge core_clk) disable iff (!rst_n)
    (task_wr[tick_counter_pkg::TSK_CLEAR] && !arm_q[tick_counter_pkg::TSK_CLEAR])
      |=> !apply[tick_counter_pkg::TSK_CLEAR];
  endproperty
  a_task_waits: assert property (p_task_waits) else $error("clear acted too soon");

endmodule

/* File: dv/low_power_tick_counter_bench.sv */
// Self-checking bench for the low-power tick counter, driven over APB.
// Assumes the design's own assertions run inside it; the bench makes the slow clock.
`timescale 1ns/1ps
module low_power_tick_counter_bench;

  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        rst_n;
  logic        low_freq_clock;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  event_pulse;
  logic        clk_request;
  logic [3:0]  lf_div;
  int          fail_count;
  int          n_checks;
  int          cyc;
  int          last_tick;
  int          tick_gap;
  int          n_tick;
  int          n_wrap;
  int          n_cmp;
  int          n_req;
  int          n_hi;

  low_power_tick_counter #(.CH(4)) low_power_tick_counter_inst
  (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .low_freq_clock (low_freq_clock),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .event_pulse    (event_pulse),
    .clk_request    (clk_request)
  );

  // ----------------------------------------------------------------
  // Clocks and monitors
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // The slow clock is scaled down to 32 core cycles so a run stays short.
  always @(posedge core_clk)
  begin
    lf_div <= lf_div + 4'h1;
    if (lf_div == 4'hF)
      low_freq_clock <= ~low_freq_clock;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (event_pulse[0] === 1'b1)
    begin
      n_tick    <= n_tick + 1;
      tick_gap  <= cyc - last_tick;
      last_tick <= cyc;
    end
    if (event_pulse[1] === 1'b1)
      n_wrap <= n_wrap + 1;
    if (event_pulse[2] === 1'b1)
      n_cmp <= n_cmp + 1;
    if (clk_request === 1'b1)
      n_req <= n_req + 1;
    n_hi <= n_hi + $countones(event_pulse[5:3]);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle behind.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err, output int n);
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    n = 1;
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      check("ready timeout", 32'h0, 32'h1);
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    int          n;
    apb(1'b1, a, d, v, e, n);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic e;
    int   n;
    apb(1'b0, a, 32'h0, v, e, n);
  endtask

  task automatic wait_tick();
    int t0;
    int k;
    t0 = n_tick;
    k  = 0;
    while (n_tick == t0 && k < 2000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 2000)
      check("tick timeout", 32'h0, 32'h1);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("unexpected watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    logic [31:0] base;
    logic        e;
    int          n;
    int          t0;
    int          r0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0; last_tick = 0; tick_gap = 0;
    n_tick = 0; n_wrap = 0; n_cmp = 0; n_req = 0;
    n_hi = 0;
    lf_div = 4'h0; low_freq_clock = 1'b0; rst_n = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset state, bus timing and an unmapped place.
    apb(1'b0, tick_counter_pkg::OFF_COUNTER, 32'h0, v, e, n);
    check("counter reset", v, 32'h0);
    check("counter read cycles", n, 32'h5);
    apb(1'b0, tick_counter_pkg::OFF_PRESC, 32'h0, v, e, n);
    check("prescaler reset", v, 32'h0);
    check("plain read cycles", n, 32'h3);
    rd(tick_counter_pkg::OFF_ROUTE, v);
    check("route reset", v, 32'h0);
    apb(1'b0, 12'h7F0, 32'h0, v, e, n);
    check("unmapped error", e, 32'h1);
    wr(tick_counter_pkg::OFF_PRESC, 32'hFFFFFFFF);
    rd(tick_counter_pkg::OFF_PRESC, v);
    check("prescaler width", v, 32'h00000FFF);
    // Tick rate with a prescaler of two.
    wr(tick_counter_pkg::OFF_PRESC, 32'h2);
    wr(tick_counter_pkg::OFF_ROUTE_SET, 32'h1);
    t0 = n_tick;
    wr(tick_counter_pkg::OFF_TASK_START, 32'h1);
    wait_tick();
    rd(tick_counter_pkg::OFF_COUNTER, v);
    check("counter follows ticks", v, n_tick - t0);
    wait_tick();
    check("tick spacing", tick_gap, 32'd96);
    rd(tick_counter_pkg::OFF_EVT_TICK, v);
    check("tick flag", v, 32'h1);
    wr(tick_counter_pkg::OFF_PRESC, 32'h5);
    rd(tick_counter_pkg::OFF_PRESC, v);
    check("prescaler locked", v, 32'h2);
    // Stop, then clear with compare value zero routed.
    wr(tick_counter_pkg::OFF_TASK_STOP, 32'h1);
    repeat (100) @(posedge core_clk);
    wr(tick_counter_pkg::OFF_ROUTE_SET, 32'h4);
    t0 = n_cmp;
    wr(tick_counter_pkg::OFF_TASK_CLEAR, 32'h1);
    repeat (100) @(posedge core_clk);
    rd(tick_counter_pkg::OFF_COUNTER, v);
    check("clear", v, 32'h0);
    check("no compare on clear", n_cmp - t0, 32'h0);
    wr(tick_counter_pkg::OFF_TASK_FORCE, 32'h1);
    rd(tick_counter_pkg::OFF_COUNTER, v);
    check("force delayed", v, 32'h0);
    repeat (100) @(posedge core_clk);
    rd(tick_counter_pkg::OFF_COUNTER, v);
    check("force value", v, 32'h00FFFFF0);
    // Wrap with every event masked: no pulse, no flag, no clock request.
    wr(tick_counter_pkg::OFF_ROUTE, 32'h0);
    wr(tick_counter_pkg::OFF_PRESC, 32'h0);
    r0 = n_req;
    wr(tick_counter_pkg::OFF_TASK_START, 32'h1);
    repeat (800) @(posedge core_clk);
    rd(tick_counter_pkg::OFF_COUNTER, v);
    check("wrapped", v < 32'h20, 32'h1);
    check("masked requests", n_req - r0, 32'h0);
    rd(tick_counter_pkg::OFF_EVT_WRAP, v);
    check("masked wrap flag", v, 32'h0);
    // Wrap again with tick and wrap routed.
    wr(tick_counter_pkg::OFF_TASK_STOP, 32'h1);
    wr(tick_counter_pkg::OFF_TASK_FORCE, 32'h1);
    repeat (100) @(posedge core_clk);
    wr(tick_counter_pkg::OFF_ROUTE_SET, 32'h3);
    t0 = n_tick; r0 = n_req; n = n_wrap;
    wr(tick_counter_pkg::OFF_TASK_START, 32'h1);
    repeat (800) @(posedge core_clk);
    check("wrap pulses", n_wrap - n, 32'h1);
    check("requests", n_req - r0, n_tick - t0);
    rd(tick_counter_pkg::OFF_EVT_WRAP, v);
    check("wrap flag", v, 32'h1);
    // Compare written two ahead of a running count, on every channel.
    // Tick and wrap share one cycle at the wrap, so they raise a single request.
    wr(tick_counter_pkg::OFF_ROUTE_SET, 32'h3C);
    wait_tick();
    rd(tick_counter_pkg::OFF_COUNTER, base);
    t0 = n_cmp;
    r0 = n_hi;
    wr(tick_counter_pkg::OFF_CC0, base + 32'h2);
    for (int i = 1; i < 4; i++)
      wr(tick_counter_pkg::OFF_CC0 + 12'(4 * i), base + 32'h2);
    repeat (3) wait_tick();
    check("compare at plus two", n_cmp - t0, 32'h1);
    check("compare other channels", n_hi - r0, 32'h3);
    rd(tick_counter_pkg::OFF_EVT_CMP0, v);
    check("compare flag", v, 32'h1);
    // An old compare value eight ahead never matches once replaced by one far ahead.
    wait_tick();
    rd(tick_counter_pkg::OFF_COUNTER, base);
    wr(tick_counter_pkg::OFF_CC0, base + 32'h8);
    wr(tick_counter_pkg::OFF_CC0, base + 32'h40);
    t0 = n_cmp;
    repeat (12) wait_tick();
    check("old compare dropped", n_cmp - t0, 32'h0);
    // Start while the count already equals the compare value.
    wr(tick_counter_pkg::OFF_TASK_STOP, 32'h1);
    repeat (100) @(posedge core_clk);
    rd(tick_counter_pkg::OFF_COUNTER, base);
    wr(tick_counter_pkg::OFF_CC0, base);
    t0 = n_cmp;
    wr(tick_counter_pkg::OFF_TASK_START, 32'h1);
    wait_tick();
    check("no compare on start", n_cmp - t0, 32'h0);
    test_done();
  end

endmodule
